// >>> verilog/tfp_pkg.sv
// Shared constants, carrier types and helpers for the temperature fault protection block
package tfp_pkg;

    localparam int CLK_PERIOD_NS = 20;
    // Base measurement slot; every evaluation interval is a whole number of slots
    localparam int MEAS_SLOT_NS  = 3000;
    localparam int MEAS_SLOT_CYC = (MEAS_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int TS_W = 16;
    localparam logic [15:0] TS_STEP_COUNTS = 16'h0036;
    localparam logic [15:0] TS_MAX_COUNTS  = 16'h35ca;
    localparam logic [7:0]  DIE_THR_MIN    = 8'h19;
    localparam logic [7:0]  DIE_THR_MAX    = 8'h96;

    localparam logic [7:0] CMD_INT_TEMP      = 8'h28;
    localparam logic [7:0] CMD_REGOUT        = 8'h69;
    localparam logic [7:0] CMD_PROTECTION_RECOVERY_SUBCOMMAND = 8'h60;
    localparam int         THERMISTOR_BIAS_ALWAYS_BIT_BIT         = 0;
    localparam int         TEMPERATURE_RECOVERY_BIT_BIT       = 2;

    localparam logic BIAS_ALWAYS_RST = 1'b0;
    localparam logic DRIVER_RST      = 1'b0;
    localparam logic NORMAL_MODE_RST = 1'b1;

    typedef struct packed {
        logic       otd_en;
        logic       die_en;
        logic       autonomous;
        logic       dsg_on_otd;
        logic       dsg_on_die;
        logic       chg_on_die;
        logic [7:0] otd_thr_code;
        logic [7:0] otd_rec_code;
        logic [7:0] otd_persist;
        logic [7:0] die_thr;
        logic [7:0] die_rec;
        logic [7:0] die_persist;
        logic [1:0] v_speed;
        logic [1:0] i_speed;
        logic [1:0] s_speed;
        logic [7:0] sleep_interval;
    } tfp_cfg_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [15:0] data;
    } tfp_cmd_t;

    typedef struct packed {
        logic otd_alert;
        logic otd_fault;
        logic die_alert;
        logic die_fault;
    } tfp_status_t;

    // Threshold code in steps of 54 counts; 255 steps land exactly on the range top
    function automatic logic [15:0] tfp_code_to_counts(input logic [7:0] code);
        logic [23:0] p;
        p = {16'h0000, code} * {8'h00, TS_STEP_COUNTS};
        return (p[15:0] > TS_MAX_COUNTS) ? TS_MAX_COUNTS : p[15:0];
    endfunction

    function automatic logic [7:0] tfp_clamp_die(input logic [7:0] t);
        if (t < DIE_THR_MIN) begin
            return DIE_THR_MIN;
        end else if (t > DIE_THR_MAX) begin
            return DIE_THR_MAX;
        end
        return t;
    endfunction

endpackage

// >>> verilog/tfp_prot_check.sv
// One threshold check with alert, persistence count, trip and recovery
`timescale 1ns/1ps
module tfp_prot_check #(
    parameter int W        = 16,
    parameter bit HOT_HIGH = 1'b0
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         enable,
    input  wire logic         sample,
    input  wire logic [W-1:0] value,
    input  wire logic [W-1:0] thr,
    input  wire logic [W-1:0] rec,
    input  wire logic [7:0]   persist,
    input  wire logic         host_rec,
    output logic              alert,
    output logic              fault
);
    import tfp_pkg::*;

    if (W < 8) begin : g_chk
        $error("tfp_prot_check: W must be at least 8");
    end

    logic       alert_q, alert_d;
    logic       fault_q, fault_d;
    logic [7:0] cnt_q, cnt_d;
    logic       hot;
    logic       cool;

    always_comb begin
        hot     = HOT_HIGH ? (value > thr) : (value < thr);
        cool    = HOT_HIGH ? (value <= rec) : (value >= rec);
        alert_d = alert_q;
        fault_d = fault_q;
        cnt_d   = cnt_q;
        if (!enable) begin
            alert_d = 1'b0;
            fault_d = 1'b0;
            cnt_d   = 8'h00;
        end else begin
            // Zero recovery threshold hands recovery to the host
            if (fault_q && host_rec && (rec == '0)) begin
                fault_d = 1'b0;
            end
            if (sample) begin
                if (fault_q) begin
                    if ((rec != '0) && cool) begin
                        fault_d = 1'b0;
                    end
                end else if (hot) begin
                    if (cnt_q >= persist) begin
                        alert_d = 1'b0;
                        fault_d = 1'b1;
                        cnt_d   = 8'h00;
                    end else begin
                        alert_d = 1'b1;
                        cnt_d   = cnt_q + 8'h01;
                    end
                end else begin
                    alert_d = 1'b0;
                    cnt_d   = 8'h00;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            alert_q <= 1'b0;
            fault_q <= 1'b0;
            cnt_q   <= 8'h00;
        end else begin
            alert_q <= alert_d;
            fault_q <= fault_d;
            cnt_q   <= cnt_d;
        end
    end

    assign alert = alert_q;
    assign fault = fault_q;

endmodule

// >>> verilog/tfp_meas_sched.sv
// Measurement request scheduler: speed-driven intervals awake, burst interval in sleep
`timescale 1ns/1ps
module tfp_meas_sched #(
    parameter int SLOT_CYC = tfp_pkg::MEAS_SLOT_CYC
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       sleep_mode,
    input  wire logic [1:0] v_speed,
    input  wire logic [1:0] i_speed,
    input  wire logic [1:0] s_speed,
    input  wire logic [7:0] sleep_interval,
    output logic            ts_req,
    output logic            die_req
);
    import tfp_pkg::*;

    if (SLOT_CYC < 1 || SLOT_CYC > 65535) begin : g_chk
        $error("tfp_meas_sched: SLOT_CYC out of range");
    end

    localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYC - 1);

    // Three speed codes sum to 9 at most, hence four bits
    function automatic logic [15:0] shift_period(input logic [3:0] sh);
        return 16'h0001 << sh;
    endfunction

    logic [15:0] div_q, div_d;
    logic [15:0] ts_cnt_q, ts_cnt_d;
    logic [15:0] die_cnt_q, die_cnt_d;
    logic        ts_req_q, ts_req_d;
    logic        die_req_q, die_req_d;
    logic        slot;
    logic [15:0] ts_per;
    logic [15:0] die_per;

    always_comb begin
        slot      = (div_q == SLOT_LAST);
        div_d     = slot ? 16'h0000 : div_q + 16'h0001;
        ts_per    = shift_period({2'b00, v_speed} + {2'b00, i_speed});
        die_per   = shift_period({2'b00, v_speed} + {2'b00, i_speed} + {2'b00, s_speed});
        // Sleep: both checks ride the same duty-cycled burst
        if (sleep_mode) begin
            ts_per  = {8'h00, sleep_interval} + 16'h0001;
            die_per = ts_per;
        end
        ts_cnt_d  = ts_cnt_q;
        die_cnt_d = die_cnt_q;
        ts_req_d  = 1'b0;
        die_req_d = 1'b0;
        if (slot) begin
            ts_cnt_d  = ts_cnt_q + 16'h0001;
            die_cnt_d = die_cnt_q + 16'h0001;
            if (ts_cnt_d >= ts_per) begin
                ts_cnt_d = 16'h0000;
                ts_req_d = 1'b1;
            end
            if (die_cnt_d >= die_per) begin
                die_cnt_d = 16'h0000;
                die_req_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            div_q     <= 16'h0000;
            ts_cnt_q  <= 16'h0000;
            die_cnt_q <= 16'h0000;
            ts_req_q  <= 1'b0;
            die_req_q <= 1'b0;
        end else begin
            div_q     <= div_d;
            ts_cnt_q  <= ts_cnt_d;
            die_cnt_q <= die_cnt_d;
            ts_req_q  <= ts_req_d;
            die_req_q <= die_req_d;
        end
    end

    assign ts_req  = ts_req_q;
    assign die_req = die_req_q;

endmodule

// >>> verilog/tfp_temp_protect.sv
// Top of the temperature fault protection: thermistor and die checks, switch drivers
`timescale 1ns/1ps
// Behaviour
// - Thermistor reading below discharge threshold flags a discharge overtemperature.
// - Thermistor bias only while measuring, unless the regulator command sets always-on.
// - Discharge threshold from zero to 13770 counts in 54-count steps.
// - Discharge check works only while its enable bit is one.
// - First detection raises alert unless persistence is zero; fault after configured 0..255 measurements.
// - Discharge evaluation spacing follows voltage and current speed settings.
// - In sleep both checks run only in the periodic measurement burst.
// - Any temperature alert forces normal mode until cleared or tripped.
// - Discharge fault turns discharge driver off under autonomous control and config bit.
// - Discharge fault recovers once reading is at or above recovery threshold.
// - Zero recovery threshold needs the host recovery subcommand with its bit set.
// - Discharge alert reads one below threshold until trip, zero at or above it.
// - Discharge recovery clears fault bit and may re-enable discharge driver.
// - Die temperature above internal threshold flags internal overtemperature.
// - Die check uses the value the host reads; alert zero at or below threshold.
// - Internal threshold from 25 to 150 degrees in one-degree steps.
// - Internal check works only while its enable bit is one.
// - Internal alert escalates to fault after configured 0..255 measurements.
// - Internal spacing follows voltage, current and shared-slot speed settings.
// - Internal trip clears internal alert and sets internal fault bit.
// - Internal trip turns off charge and discharge drivers under autonomous control, each by its bit.
// - Internal fault recovers at or below recovery threshold, re-enabling drivers.
module tfp_temp_protect #(
    parameter int SLOT_CYC = tfp_pkg::MEAS_SLOT_CYC
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire tfp_pkg::tfp_cfg_t   cfg,
    input  wire tfp_pkg::tfp_cmd_t   cmd,
    input  wire logic                sleep_request,
    input  wire logic                dsg_request,
    input  wire logic                chg_request,
    input  wire logic [15:0]         ts_adc_value,
    input  wire logic                ts_adc_valid,
    input  wire logic [15:0]         die_temp_value,
    input  wire logic                die_adc_valid,
    output logic                     ts_adc_req,
    output logic                     die_adc_req,
    output logic                     thermistor_bias,
    output tfp_pkg::tfp_status_t     status,
    output logic                     discharge_switch_driver,
    output logic                     charge_switch_driver,
    output logic                     normal_mode,
    output logic [15:0]              die_temp_readback,
    output logic                     die_temp_read_valid
);
    import tfp_pkg::*;

    if (SLOT_CYC < 1) begin : g_chk
        $error("tfp_temp_protect: SLOT_CYC must be at least 1");
    end

    // Command decode
    logic bias_always_q, bias_always_d;
    logic host_temp_rec;
    logic read_temp;

    always_comb begin
        bias_always_d = bias_always_q;
        host_temp_rec = 1'b0;
        read_temp     = 1'b0;
        if (cmd.valid) begin
            if (cmd.code == CMD_REGOUT) begin
                bias_always_d = cmd.data[THERMISTOR_BIAS_ALWAYS_BIT_BIT];
            end else if (cmd.code == CMD_PROTECTION_RECOVERY_SUBCOMMAND) begin
                host_temp_rec = cmd.data[TEMPERATURE_RECOVERY_BIT_BIT];
            end else if (cmd.code == CMD_INT_TEMP) begin
                read_temp = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bias_always_q <= BIAS_ALWAYS_RST;
        end else begin
            bias_always_q <= bias_always_d;
        end
    end

    // Measurement scheduling and result acceptance
    logic ts_req_w;
    logic die_req_w;
    logic normal_q, normal_d;

    tfp_meas_sched #(
        .SLOT_CYC       (SLOT_CYC)
    ) u_sched (
        .clk            (clk),
        .srst           (srst),
        .sleep_mode     (!normal_q),
        .v_speed        (cfg.v_speed),
        .i_speed        (cfg.i_speed),
        .s_speed        (cfg.s_speed),
        .sleep_interval (cfg.sleep_interval),
        .ts_req         (ts_req_w),
        .die_req        (die_req_w)
    );

    logic        ts_pend_q, ts_pend_d;
    logic        die_pend_q, die_pend_d;
    logic        bias_q, bias_d;
    logic        ts_sample;
    logic        die_sample;
    logic [15:0] die_last_q, die_last_d;
    logic [15:0] die_cmp;
    logic [15:0] rdbk_q, rdbk_d;
    logic        rdbk_vld_q, rdbk_vld_d;

    always_comb begin
        // Results are only evaluated when the scheduler asked for them
        ts_sample  = ts_adc_valid && ts_pend_q;
        die_sample = die_adc_valid && die_pend_q;
        ts_pend_d  = ts_pend_q;
        die_pend_d = die_pend_q;
        if (ts_req_w) begin
            ts_pend_d = 1'b1;
        end else if (ts_sample) begin
            ts_pend_d = 1'b0;
        end
        if (die_req_w) begin
            die_pend_d = 1'b1;
        end else if (die_sample) begin
            die_pend_d = 1'b0;
        end
        // Bias stays up from request until conversion ends, or always on command
        bias_d     = bias_always_d || ts_pend_d;
        die_last_d = die_sample ? die_temp_value : die_last_q;
        // Negative die readings can never be over temperature
        die_cmp    = die_temp_value[15] ? 16'h0000 : die_temp_value;
        rdbk_d     = read_temp ? die_last_q : rdbk_q;
        rdbk_vld_d = read_temp;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ts_pend_q  <= 1'b0;
            die_pend_q <= 1'b0;
            bias_q     <= BIAS_ALWAYS_RST;
            die_last_q <= 16'h0000;
            rdbk_q     <= 16'h0000;
            rdbk_vld_q <= 1'b0;
        end else begin
            ts_pend_q  <= ts_pend_d;
            die_pend_q <= die_pend_d;
            bias_q     <= bias_d;
            die_last_q <= die_last_d;
            rdbk_q     <= rdbk_d;
            rdbk_vld_q <= rdbk_vld_d;
        end
    end

    // Threshold preparation
    logic [15:0] otd_thr;
    logic [15:0] otd_rec;
    logic [15:0] die_thr;
    logic [15:0] die_rec;

    always_comb begin
        otd_thr = tfp_code_to_counts(cfg.otd_thr_code);
        otd_rec = tfp_code_to_counts(cfg.otd_rec_code);
        die_thr = {8'h00, tfp_clamp_die(cfg.die_thr)};
        // Recovery keeps zero as the host-recovery marker, so it is not clamped
        die_rec = {8'h00, cfg.die_rec};
    end

    logic otd_alert;
    logic otd_fault;
    logic die_alert;
    logic die_fault;

    // Hot means a low reading on the thermistor
    tfp_prot_check #(
        .W        (TS_W),
        .HOT_HIGH (1'b0)
    ) u_otd (
        .clk      (clk),
        .srst     (srst),
        .enable   (cfg.otd_en),
        .sample   (ts_sample),
        .value    (ts_adc_value),
        .thr      (otd_thr),
        .rec      (otd_rec),
        .persist  (cfg.otd_persist),
        .host_rec (host_temp_rec),
        .alert    (otd_alert),
        .fault    (otd_fault)
    );

    tfp_prot_check #(
        .W        (TS_W),
        .HOT_HIGH (1'b1)
    ) u_die (
        .clk      (clk),
        .srst     (srst),
        .enable   (cfg.die_en),
        .sample   (die_sample),
        .value    (die_cmp),
        .thr      (die_thr),
        .rec      (die_rec),
        .persist  (cfg.die_persist),
        .host_rec (host_temp_rec),
        .alert    (die_alert),
        .fault    (die_fault)
    );

    // Mode and switch drivers
    logic dsg_q, dsg_d;
    logic chg_q, chg_d;
    logic dsg_block;
    logic chg_block;

    always_comb begin
        // An alert keeps the part awake so the persistence count runs at full rate
        normal_d  = !sleep_request || otd_alert || die_alert;
        dsg_block = cfg.autonomous &&
                    ((otd_fault && cfg.dsg_on_otd) || (die_fault && cfg.dsg_on_die));
        chg_block = cfg.autonomous && die_fault && cfg.chg_on_die;
        // Drivers return to the requested state as soon as the fault bit drops
        dsg_d     = dsg_request && !dsg_block;
        chg_d     = chg_request && !chg_block;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            normal_q <= NORMAL_MODE_RST;
            dsg_q    <= DRIVER_RST;
            chg_q    <= DRIVER_RST;
        end else begin
            normal_q <= normal_d;
            dsg_q    <= dsg_d;
            chg_q    <= chg_d;
        end
    end

    assign ts_adc_req              = ts_req_w;
    assign die_adc_req             = die_req_w;
    assign thermistor_bias         = bias_q;
    assign status.otd_alert        = otd_alert;
    assign status.otd_fault        = otd_fault;
    assign status.die_alert        = die_alert;
    assign status.die_fault        = die_fault;
    assign discharge_switch_driver = dsg_q;
    assign charge_switch_driver    = chg_q;
    assign normal_mode             = normal_q;
    assign die_temp_readback       = rdbk_q;
    assign die_temp_read_valid     = rdbk_vld_q;

endmodule

// >>> dv/tfp_temp_protect_monitor.sv
// Checker bound to the temperature fault protection top
`timescale 1ns/1ps
module tfp_temp_protect_monitor
    import tfp_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire tfp_cfg_t    cfg,
    input wire tfp_cmd_t    cmd,
    input wire tfp_status_t status,
    input wire logic        thermistor_bias,
    input wire logic        discharge_switch_driver,
    input wire logic        charge_switch_driver,
    input wire logic        normal_mode,
    input wire logic        die_temp_read_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_dsg_off;
        status.otd_fault && cfg.autonomous && cfg.dsg_on_otd |=> !discharge_switch_driver;
    endproperty
    a_dsg_off: assert property (p_dsg_off) else $error("discharge driver on in fault");

    property p_chg_off;
        status.die_fault && cfg.autonomous && cfg.chg_on_die |=> !charge_switch_driver;
    endproperty
    a_chg_off: assert property (p_chg_off) else $error("charge driver on in die fault");

    property p_otd_trip;
        $rose(status.otd_fault) |-> !status.otd_alert;
    endproperty
    a_otd_trip: assert property (p_otd_trip) else $error("alert kept at trip");

    property p_die_trip;
        $rose(status.die_fault) |-> !status.die_alert;
    endproperty
    a_die_trip: assert property (p_die_trip) else $error("die alert kept at trip");

    property p_bias;
        cmd.valid && cmd.code == CMD_REGOUT && cmd.data[THERMISTOR_BIAS_ALWAYS_BIT_BIT] |=> thermistor_bias;
    endproperty
    a_bias: assert property (p_bias) else $error("bias not held on");

    property p_read;
        cmd.valid && cmd.code == CMD_INT_TEMP |=> die_temp_read_valid;
    endproperty
    a_read: assert property (p_read) else $error("no readback answer");

    property p_normal;
        status.otd_alert || status.die_alert |=> normal_mode;
    endproperty
    a_normal: assert property (p_normal) else $error("sleep kept during alert");

    property p_otd_dis;
        !cfg.otd_en ##1 !cfg.otd_en |-> !status.otd_alert && !status.otd_fault;
    endproperty
    a_otd_dis: assert property (p_otd_dis) else $error("disabled check flagged");

    property p_die_dis;
        !cfg.die_en ##1 !cfg.die_en |-> !status.die_alert && !status.die_fault;
    endproperty
    a_die_dis: assert property (p_die_dis) else $error("disabled die check flagged");

    c_otd_fault: cover property ($rose(status.otd_fault));
    c_die_fault: cover property ($rose(status.die_fault));
    c_wake: cover property ($rose(normal_mode));
endmodule

bind tfp_temp_protect tfp_temp_protect_monitor mon_i (
    .clk(clk), .srst(srst), .cfg(cfg), .cmd(cmd), .status(status),
    .thermistor_bias(thermistor_bias), .discharge_switch_driver(discharge_switch_driver),
    .charge_switch_driver(charge_switch_driver), .normal_mode(normal_mode),
    .die_temp_read_valid(die_temp_read_valid)
);

// >>> dv/tfp_adc_model.sv
// Converter model: answers each request after lat cycles
`timescale 1ns/1ps
module tfp_adc_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [3:0]  lat,
    input  wire logic        ts_adc_req,
    input  wire logic        die_adc_req,
    input  wire logic [15:0] ts_level,
    input  wire logic [15:0] die_level,
    output logic [15:0]      ts_adc_value,
    output logic             ts_adc_valid,
    output logic [15:0]      die_temp_value,
    output logic             die_adc_valid
);
    logic [3:0] ts_cnt;
    logic [3:0] die_cnt;
    // Data toggles outside valid, so a stale result never looks usable
    always @(posedge clk) begin
        ts_adc_valid <= (ts_cnt == 4'h1);
        die_adc_valid <= (die_cnt == 4'h1);
        ts_adc_value <= (ts_cnt == 4'h1) ? ts_level : ~ts_adc_value;
        die_temp_value <= (die_cnt == 4'h1) ? die_level : ~die_temp_value;
        ts_cnt <= srst ? 4'h0 : (ts_cnt != 4'h0) ? ts_cnt - 4'h1 : (ts_adc_req ? lat : 4'h0);
        die_cnt <= srst ? 4'h0 : (die_cnt != 4'h0) ? die_cnt - 4'h1 : (die_adc_req ? lat : 4'h0);
    end
endmodule

// >>> dv/test_tfp_temp_protect.sv
// Bench of the temperature fault protection top
`timescale 1ns/1ps
module test_tfp_temp_protect;
    import tfp_pkg::*;
    localparam int SLOT = 4;
    logic clk, srst, sleep_request, dsg_request, chg_request;
    tfp_cfg_t cfg;
    tfp_cmd_t cmd;
    logic [15:0] ts_level, die_level, ts_adc_value, die_temp_value, die_temp_readback;
    logic [3:0] lat;
    logic ts_adc_valid, die_adc_valid, ts_adc_req, die_adc_req, thermistor_bias;
    logic discharge_switch_driver, charge_switch_driver, normal_mode, die_temp_read_valid;
    tfp_status_t status;
    int err_count, n_tests, cycles;
    // Bits 3..0 are otd_alert, otd_fault, die_alert, die_fault
    wire [7:0] obs = {normal_mode, charge_switch_driver, discharge_switch_driver,
                      thermistor_bias, status};

    tfp_temp_protect #(.SLOT_CYC(SLOT)) tfp_temp_protect_i (
        .clk(clk), .srst(srst), .cfg(cfg), .cmd(cmd), .sleep_request(sleep_request),
        .dsg_request(dsg_request), .chg_request(chg_request), .ts_adc_value(ts_adc_value),
        .ts_adc_valid(ts_adc_valid), .die_temp_value(die_temp_value),
        .die_adc_valid(die_adc_valid), .ts_adc_req(ts_adc_req), .die_adc_req(die_adc_req),
        .thermistor_bias(thermistor_bias), .status(status),
        .discharge_switch_driver(discharge_switch_driver),
        .charge_switch_driver(charge_switch_driver), .normal_mode(normal_mode),
        .die_temp_readback(die_temp_readback), .die_temp_read_valid(die_temp_read_valid));

    tfp_adc_model tfp_adc_model_i (
        .clk(clk), .srst(srst), .lat(lat), .ts_adc_req(ts_adc_req),
        .die_adc_req(die_adc_req), .ts_level(ts_level), .die_level(die_level),
        .ts_adc_value(ts_adc_value), .ts_adc_valid(ts_adc_valid),
        .die_temp_value(die_temp_value), .die_adc_valid(die_adc_valid));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_bit(input int idx, input logic v);
        for (int k = 0; k < 400 && obs[idx] !== v; k++) @(negedge clk);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic send(input logic [7:0] code, input logic [15:0] data);
        @(posedge clk);
        cmd <= {1'b1, code, data};
        @(posedge clk);
        cmd.valid <= 1'b0;
        @(negedge clk);
    endtask

    task automatic gap(input bit ts, output int n);
        for (int k = 0; k < 200 && (ts ? ts_adc_req : die_adc_req) !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        for (n = 1; n < 200 && (ts ? ts_adc_req : die_adc_req) !== 1'b1; n++) @(negedge clk);
    endtask

    task automatic t_otd;
        @(posedge clk) ts_level <= 16'(100 * 54);
        idle(40);
        check(16'(obs[3]), 16'h0000);
        @(posedge clk) ts_level <= 16'(100 * 54 - 1);
        wait_bit(3, 1'b1);
        check(16'(obs[3:2]), 16'h0002);
        wait_bit(2, 1'b1);
        check(16'(obs[3:2]), 16'h0001);
        idle(2);
        check(16'(obs[6:5]), 16'h0002);
        @(posedge clk) ts_level <= 16'(110 * 54 - 1);
        idle(40);
        check(16'(obs[2]), 16'h0001);
        @(posedge clk) ts_level <= 16'(110 * 54);
        wait_bit(5, 1'b1);
        check(16'(obs[5:2]), 16'h000c);
        @(posedge clk) begin
            cfg.otd_thr_code <= 8'hff;
            cfg.otd_persist <= 8'hff;
            ts_level <= 16'(255 * 54);
        end
        idle(40);
        check(16'(obs[3]), 16'h0000);
        @(posedge clk) ts_level <= 16'(255 * 54 - 1);
        wait_bit(3, 1'b1);
        check(16'(obs[3]), 16'h0001);
        @(posedge clk) begin
            ts_level <= 16'h3800;
            cfg.otd_thr_code <= 8'h64;
            cfg.otd_persist <= 8'h02;
        end
        wait_bit(3, 1'b0);
        $display("test otd done");
    endtask

    task automatic t_die;
        @(posedge clk) die_level <= 16'h003c;
        idle(40);
        check(16'(obs[1:0]), 16'h0000);
        @(posedge clk) die_level <= 16'h003d;
        wait_bit(1, 1'b1);
        wait_bit(0, 1'b1);
        check(16'(obs[1:0]), 16'h0001);
        idle(2);
        check(16'(obs[6:5]), 16'h0000);
        @(posedge clk) die_level <= 16'h0033;
        idle(40);
        check(16'(obs[0]), 16'h0001);
        @(posedge clk) die_level <= 16'h0032;
        wait_bit(6, 1'b1);
        check(16'(obs[6:5]), 16'h0003);
        @(posedge clk) begin
            cfg.die_rec <= 8'h00;
            cfg.die_persist <= 8'h00;
            die_level <= 16'h003d;
        end
        wait_bit(0, 1'b1);
        check(16'(obs[1:0]), 16'h0001);
        @(posedge clk) die_level <= 16'h0014;
        idle(40);
        check(16'(obs[0]), 16'h0001);
        send(CMD_PROTECTION_RECOVERY_SUBCOMMAND, 16'h0004);
        check(16'(obs[0]), 16'h0000);
        send(CMD_INT_TEMP, 16'h0000);
        check({die_temp_read_valid, 15'h0000}, 16'h8000);
        check(die_temp_readback, 16'h0014);
        $display("test die done");
    endtask

    task automatic t_bias_dis;
        send(CMD_REGOUT, 16'h0001);
        idle(30);
        check(16'(obs[4]), 16'h0001);
        send(CMD_REGOUT, 16'h0000);
        @(posedge clk) begin
            {cfg.otd_en, cfg.die_en} <= 2'b00;
            ts_level <= 16'h0010;
            die_level <= 16'h0090;
        end
        idle(40);
        check(16'(obs[3:0]), 16'h0000);
        @(posedge clk) begin
            ts_level <= 16'h3800;
            die_level <= 16'h001e;
            {cfg.otd_en, cfg.die_en} <= 2'b11;
        end
        $display("test bias done");
    endtask

    task automatic t_sched;
        int n;
        @(posedge clk) {cfg.v_speed, cfg.i_speed} <= 4'h5;
        idle(40);
        gap(1'b1, n);
        check(16'(n), 16'(4 * SLOT));
        @(posedge clk) cfg.s_speed <= 2'h1;
        idle(70);
        gap(1'b0, n);
        check(16'(n), 16'(8 * SLOT));
        @(posedge clk) sleep_request <= 1'b1;
        wait_bit(7, 1'b0);
        gap(1'b1, n);
        check(16'(n), 16'(2 * SLOT));
        @(posedge clk) begin
            cfg.otd_persist <= 8'hff;
            ts_level <= 16'h0010;
        end
        wait_bit(3, 1'b1);
        idle(1);
        check(16'(obs[7]), 16'h0001);
        $display("test sched done");
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run;
        end
    end

    initial begin
        srst = 1'b1;
        cmd = '0;
        sleep_request = 1'b0;
        dsg_request = 1'b0;
        chg_request = 1'b0;
        ts_level = 16'h3800;
        die_level = 16'h001e;
        lat = 4'h3;
        // Fields in struct order
        cfg = {6'h3f, 8'h64, 8'h6e, 8'h02, 8'h3c, 8'h32, 8'h01, 6'h00, 8'h01};
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check(16'(obs), 16'h0080);
        @(posedge clk) begin
            dsg_request <= 1'b1;
            chg_request <= 1'b1;
        end
        wait_bit(6, 1'b1);
        t_otd();
        @(posedge clk) lat <= 4'h1;
        t_die();
        t_bias_dis();
        t_sched();
        complete_run();
    end
endmodule
